// *** tmc_defines.svh ***
/*
  Offsets, field positions, reset values and timing counts for the
  16-bit timer control, compare and capture block.
  Assumes inclusion from the package, the design modules and the bench.
*/
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH

// =====================================================================
// register offsets (8-bit register port, byte addresses)
`define TMC_OFS_CTRL_B 8'h2E
`define TMC_OFS_CTRL_A 8'h2F
`define TMC_OFS_CNT_LO 8'h2C
`define TMC_OFS_CNT_HI 8'h2D
`define TMC_OFS_CMPA_LO 8'h2A
`define TMC_OFS_CMPA_HI 8'h2B
`define TMC_OFS_CMPB_LO 8'h28
`define TMC_OFS_CMPB_HI 8'h29
`define TMC_OFS_CAP_LO 8'h26
`define TMC_OFS_CAP_HI 8'h27
`define TMC_OFS_FLAGS 8'h30

// =====================================================================
// control register a fields
`define TMC_A_MODE_A_HI 7
`define TMC_A_MODE_A_LO 6
`define TMC_A_MODE_B_HI 5
`define TMC_A_MODE_B_LO 4
`define TMC_A_FORCE_A 3
`define TMC_A_FORCE_B 2
`define TMC_A_PWM_HI 1
`define TMC_A_PWM_LO 0
// control register b fields
`define TMC_B_NOISE 7
`define TMC_B_EDGE 6
`define TMC_B_CLEAR 3
`define TMC_B_CS_HI 2
`define TMC_B_CS_LO 0
`define TMC_B_RW_MASK 8'hCF

// =====================================================================
// reset values and counts
`define TMC_CTRL_A_RST 8'h00
`define TMC_CTRL_B_RST 8'h00
`define TMC_NOISE_SAMPLES 4
`define TMC_DIV_8 8
`define TMC_DIV_64 64
`define TMC_DIV_256 256
`define TMC_DIV_1024 1024
`define TMC_TOP_8 16'h00FF
`define TMC_TOP_9 16'h01FF
`define TMC_TOP_10 16'h03FF

`endif

// *** tmc_pkg.sv ***
/*
  Types for the timer control, compare and capture block.
  Assumes the defines header sits beside it.
*/
`include "tmc_defines.svh"

package tmc_pkg;
  // =====================================================================
  // clock select codes
  typedef enum logic [2:0] {
    TMC_CS_STOP = 3'h0,
    TMC_CS_DIV1 = 3'h1,
    TMC_CS_DIV8 = 3'h2,
    TMC_CS_DIV64 = 3'h3,
    TMC_CS_DIV256 = 3'h4,
    TMC_CS_DIV1024 = 3'h5,
    TMC_CS_EXT_FALL = 3'h6,
    TMC_CS_EXT_RISE = 3'h7
  } tmc_clk_sel_t;

  // compare output pin actions
  typedef enum logic [1:0] {
    TMC_OUT_OFF = 2'h0,
    TMC_OUT_TOGGLE = 2'h1,
    TMC_OUT_CLEAR = 2'h2,
    TMC_OUT_SET = 2'h3
  } tmc_out_mode_t;

  // control register a as a packed record
  typedef struct packed {
    tmc_out_mode_t mode_a;
    tmc_out_mode_t mode_b;
    logic force_a;
    logic force_b;
    logic [1:0] pwm_sel;
  } tmc_ctrl_a_t;

  // control register b as a packed record
  typedef struct packed {
    logic noise_cancel;
    logic edge_rise;
    logic [1:0] reserved;
    logic clear_on_cmp;
    tmc_clk_sel_t clk_sel;
  } tmc_ctrl_b_t;

  // pin drive group for one compare output
  typedef struct packed {
    logic out;
    logic oe;
  } tmc_pin_t;

  // capture filter state
  typedef enum logic [1:0] {
    TMC_CAP_IDLE = 2'b01,
    TMC_CAP_ARMED = 2'b10
  } tmc_cap_state_t;
endpackage

// *** tmc_prescaler.sv ***
/*
  Prescaler: turns the clock select code into a one-cycle timer tick.
  Assumes the count pin is already synchronised to ref_clk.
*/
`timescale 1ns/1ps
`include "tmc_defines.svh"

module tmc_prescaler
  import tmc_pkg::*;
#(
  parameter int DIV_MAX = `TMC_DIV_1024
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire tmc_clk_sel_t clk_sel,
  input wire logic count_sync,
  output logic tick
);
  // elaboration stop: the slowest divide must fit in the counter
  if (DIV_MAX < `TMC_DIV_1024) begin : g_bad_div
    $error("prescaler counter too narrow");
  end

  // =====================================================================
  // free running divider on the main clock
  logic [$clog2(DIV_MAX)-1:0] div_cnt;
  logic count_prev;

  // divider runs from the main oscillator clock only
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // previous count pin level for edge detection
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      count_prev <= 1'b0;
    end else begin
      count_prev <= count_sync;
    end
  end

  function automatic logic div_hit(input logic [$clog2(DIV_MAX)-1:0] c, input int n);
    div_hit = (c % n) == (n - 1);
  endfunction

  // select decode
  always_comb begin
    case (clk_sel)
      TMC_CS_STOP: tick = 1'b0;
      TMC_CS_DIV1: tick = 1'b1;
      TMC_CS_DIV8: tick = div_hit(div_cnt, `TMC_DIV_8);
      TMC_CS_DIV64: tick = div_hit(div_cnt, `TMC_DIV_64);
      TMC_CS_DIV256: tick = div_hit(div_cnt, `TMC_DIV_256);
      TMC_CS_DIV1024: tick = div_hit(div_cnt, `TMC_DIV_1024);
      // pin edges count whatever its direction
      TMC_CS_EXT_FALL: tick = count_prev & ~count_sync;
      TMC_CS_EXT_RISE: tick = ~count_prev & count_sync;
      default: tick = 1'b0;
    endcase
  end
endmodule

// *** tmc_timer.sv ***
/*
  Timer/counter core: control registers, 16-bit counter, two compare
  channels with pin actions, input capture with optional noise filter.
  Assumes a single-cycle register port master on ref_clk and pins that
  come straight from the pads.
*/
`timescale 1ns/1ps
`include "tmc_defines.svh"

// Notes on behaviour
// - match applies two-bit pin mode per channel
// - mode acts on own pin, drive when output
// - pwm mode reinterprets compare output bits
// - force acts like match, no flag, no clear
// - force with mode write uses old mode
// - force bits read back as zero
// - force ignored in any pwm mode
// - pwm select picks off, 8, 9, 10 bits
// - no filter: capture on first sampled edge
// - filter: four equal samples before capture
// - edge select zero falling, one rising
// - control b bits 5,4 read zero
// - clear on compare a next timer cycle
// - no clear: matches leave counter alone
// - pwm: up-down or wrap at top
// - clock select eight source codes
// - count pin counts even as output
// - prescaler driven by main clock
// - each value held eight cycles at div8
// - compare flag set cycle after match
// - counter write blocks next timer match
// - count pin sampled on main clock rise
module tmc_timer
  import tmc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic dir_cmp_a,
  input wire logic dir_cmp_b,
  output tmc_pin_t cmp_a_pin,
  output tmc_pin_t cmp_b_pin,
  input wire logic capture_pin,
  input wire logic count_pin,
  output logic cmp_a_flag,
  output logic cmp_b_flag,
  output logic capture_flag
);
  // elaboration stop: the byte-wide register port serves 16 bits only
  if (CNT_W != 16) begin : g_bad_width
    $error("counter must be 16 bits wide");
  end

  // =====================================================================
  // registers
  tmc_ctrl_a_t ctrl_a;
  tmc_ctrl_b_t ctrl_b;
  logic [CNT_W-1:0] counter_value;
  logic [CNT_W-1:0] cmp_a_value;
  logic [CNT_W-1:0] cmp_b_value;
  logic [CNT_W-1:0] capture_value;
  logic [7:0] hi_temp;
  logic count_down;
  logic cnt_written;
  logic out_a;
  logic out_b;

  wire wr_a = reg_write && reg_addr == `TMC_OFS_CTRL_A;
  wire wr_b = reg_write && reg_addr == `TMC_OFS_CTRL_B;
  wire wr_cnt = reg_write && reg_addr == `TMC_OFS_CNT_LO;
  wire pwm_on = ctrl_a.pwm_sel != 2'h0;

  // control a; force bits never stored so they read zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_a <= tmc_ctrl_a_t'(`TMC_CTRL_A_RST);
    end else if (wr_a) begin
      ctrl_a <= tmc_ctrl_a_t'(reg_wdata & 8'hF3);
    end
  end

  // control b; reserved bits forced low
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_b <= tmc_ctrl_b_t'(`TMC_CTRL_B_RST);
    end else if (wr_b) begin
      ctrl_b <= tmc_ctrl_b_t'(reg_wdata & `TMC_B_RW_MASK);
    end
  end

  // compare registers and high-byte staging, high byte first
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hi_temp <= 8'h00;
      cmp_a_value <= '0;
      cmp_b_value <= '0;
    end else if (reg_write) begin
      case (reg_addr)
        `TMC_OFS_CNT_HI, `TMC_OFS_CMPA_HI, `TMC_OFS_CMPB_HI: hi_temp <= reg_wdata;
        `TMC_OFS_CMPA_LO: cmp_a_value <= {hi_temp, reg_wdata};
        `TMC_OFS_CMPB_LO: cmp_b_value <= {hi_temp, reg_wdata};
        default: ;
      endcase
    end
  end

  // =====================================================================
  // count pin synchroniser and prescaler
  logic cnt_s1;
  logic cnt_s2;
  logic tick;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_s1 <= 1'b0;
      cnt_s2 <= 1'b0;
    end else begin
      cnt_s1 <= count_pin;
      cnt_s2 <= cnt_s1;
    end
  end

  tmc_prescaler u_presc (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_sel(ctrl_b.clk_sel),
    .count_sync(cnt_s2),
    .tick(tick)
  );

  // =====================================================================
  // counter
  logic [CNT_W-1:0] top;
  logic match_a;
  logic match_b;

  // resolution decode
  always_comb begin
    case (ctrl_a.pwm_sel)
      2'h1: top = `TMC_TOP_8;
      2'h2: top = `TMC_TOP_9;
      2'h3: top = `TMC_TOP_10;
      default: top = '1;
    endcase
  end

  // equality compare, blocked after a counter write
  assign match_a = counter_value == cmp_a_value && !cnt_written;
  assign match_b = counter_value == cmp_b_value && !cnt_written;

  // write-block window lasts until the next timer tick
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_written <= 1'b0;
    end else if (wr_cnt) begin
      cnt_written <= 1'b1;
    end else if (tick) begin
      cnt_written <= 1'b0;
    end
  end

  // counter moves only on timer ticks, so values hold for the divide
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      counter_value <= '0;
      count_down <= 1'b0;
    end else if (wr_cnt) begin
      counter_value <= {hi_temp, reg_wdata};
    end else if (tick) begin
      if (!pwm_on) begin
        // clear follows a compare a match
        if (ctrl_b.clear_on_cmp && match_a) begin
          counter_value <= '0;
        end else begin
          counter_value <= counter_value + 1'b1;
        end
      end else if (ctrl_b.clear_on_cmp) begin
        // wrap at top
        counter_value <= (counter_value >= top) ? '0 : counter_value + 1'b1;
      end else begin
        // up-down between zero and top
        if (!count_down && counter_value >= top) begin
          count_down <= 1'b1;
          counter_value <= counter_value - 1'b1;
        end else if (count_down && counter_value == '0) begin
          count_down <= 1'b0;
          counter_value <= counter_value + 1'b1;
        end else begin
          counter_value <= count_down ? counter_value - 1'b1 : counter_value + 1'b1;
        end
      end
    end
  end

  // =====================================================================
  // compare outputs
  function automatic logic pin_next(input tmc_out_mode_t m, input logic cur);
    case (m)
      TMC_OUT_TOGGLE: pin_next = ~cur;
      TMC_OUT_CLEAR: pin_next = 1'b0;
      TMC_OUT_SET: pin_next = 1'b1;
      default: pin_next = cur;
    endcase
  endfunction

  // pwm: clear on up-count match, set on down-count match for mode 2,
  // inverted for mode 3; modes 0 and 1 leave the pin alone
  function automatic logic pwm_next(input tmc_out_mode_t m, input logic cur, input logic dn);
    case (m)
      TMC_OUT_CLEAR: pwm_next = dn;
      TMC_OUT_SET: pwm_next = ~dn;
      default: pwm_next = cur;
    endcase
  endfunction

  // force uses the stored mode, since ctrl_a updates only after this edge
  wire force_a = wr_a && reg_wdata[`TMC_A_FORCE_A] && !pwm_on;
  wire force_b = wr_a && reg_wdata[`TMC_A_FORCE_B] && !pwm_on;
  wire ev_a = tick && match_a;
  wire ev_b = tick && match_b;

  // channel a pin state from its own mode bits
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      out_a <= 1'b0;
    end else if (pwm_on && ev_a) begin
      out_a <= pwm_next(ctrl_a.mode_a, out_a, count_down);
    end else if (ev_a || force_a) begin
      out_a <= pin_next(ctrl_a.mode_a, out_a);
    end
  end

  // channel b pin state from its own mode bits
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      out_b <= 1'b0;
    end else if (pwm_on && ev_b) begin
      out_b <= pwm_next(ctrl_a.mode_b, out_b, count_down);
    end else if (ev_b || force_b) begin
      out_b <= pin_next(ctrl_a.mode_b, out_b);
    end
  end

  // pins driven only when connected and direction says output
  assign cmp_a_pin.out = out_a;
  assign cmp_a_pin.oe = dir_cmp_a && ctrl_a.mode_a != TMC_OUT_OFF;
  assign cmp_b_pin.out = out_b;
  assign cmp_b_pin.oe = dir_cmp_b && ctrl_a.mode_b != TMC_OUT_OFF;

  // =====================================================================
  // input capture
  logic cap_s1;
  logic cap_s2;
  logic [`TMC_NOISE_SAMPLES-1:0] cap_hist;
  logic cap_fire;
  tmc_cap_state_t cap_state;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cap_s1 <= 1'b0;
      cap_s2 <= 1'b0;
      cap_hist <= '0;
    end else begin
      cap_s1 <= capture_pin;
      cap_s2 <= cap_s1;
      cap_hist <= {cap_hist[`TMC_NOISE_SAMPLES-2:0], cap_s2};
    end
  end

  // filtered level must be four equal samples of the active level
  wire all_act = ctrl_b.edge_rise ? &cap_hist : ~|cap_hist;
  wire raw_act = ctrl_b.edge_rise ? cap_s2 : ~cap_s2;
  wire act_lvl = ctrl_b.noise_cancel ? all_act : raw_act;

  // edge detect: arm on inactive level, fire on first active sample
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cap_state <= TMC_CAP_IDLE;
    end else begin
      case (cap_state)
        TMC_CAP_IDLE: if (!act_lvl) cap_state <= TMC_CAP_ARMED;
        TMC_CAP_ARMED: if (act_lvl) cap_state <= TMC_CAP_IDLE;
        default: cap_state <= TMC_CAP_IDLE;
      endcase
    end
  end
  assign cap_fire = cap_state == TMC_CAP_ARMED && act_lvl;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      capture_value <= '0;
    end else if (cap_fire) begin
      capture_value <= counter_value;
    end
  end

  // =====================================================================
  // event flags, set wins over clear; write one to clear
  wire clr_flags = reg_write && reg_addr == `TMC_OFS_FLAGS;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cmp_a_flag <= 1'b0;
      cmp_b_flag <= 1'b0;
      capture_flag <= 1'b0;
    end else begin
      // flag rises one cycle after the match; force never sets it
      cmp_a_flag <= ev_a | (cmp_a_flag & ~(clr_flags & reg_wdata[0]));
      cmp_b_flag <= ev_b | (cmp_b_flag & ~(clr_flags & reg_wdata[1]));
      capture_flag <= cap_fire | (capture_flag & ~(clr_flags & reg_wdata[2]));
    end
  end

  // =====================================================================
  // read port, data one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `TMC_OFS_CTRL_A: reg_rdata <= ctrl_a;
        `TMC_OFS_CTRL_B: reg_rdata <= ctrl_b;
        `TMC_OFS_CNT_LO: reg_rdata <= counter_value[7:0];
        `TMC_OFS_CNT_HI: reg_rdata <= counter_value[15:8];
        `TMC_OFS_CMPA_LO: reg_rdata <= cmp_a_value[7:0];
        `TMC_OFS_CMPA_HI: reg_rdata <= cmp_a_value[15:8];
        `TMC_OFS_CMPB_LO: reg_rdata <= cmp_b_value[7:0];
        `TMC_OFS_CMPB_HI: reg_rdata <= cmp_b_value[15:8];
        `TMC_OFS_CAP_LO: reg_rdata <= capture_value[7:0];
        `TMC_OFS_CAP_HI: reg_rdata <= capture_value[15:8];
        `TMC_OFS_FLAGS: reg_rdata <= {5'h00, capture_flag, cmp_b_flag, cmp_a_flag};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // =====================================================================
  // checks
  property p_flag_a;
    @(posedge ref_clk) disable iff (sys_rst) ev_a |=> cmp_a_flag;
  endproperty
  a_flag_a: assert property (p_flag_a) else $error("flag a missed match");

  property p_force_noflag;
    @(posedge ref_clk) disable iff (sys_rst)
      force_a && !ev_a && !cmp_a_flag |=> !cmp_a_flag;
  endproperty
  a_force_noflag: assert property (p_force_noflag) else $error("force set flag");

  property p_force_zero;
    @(posedge ref_clk) disable iff (sys_rst) !ctrl_a.force_a && !ctrl_a.force_b;
  endproperty
  a_force_zero: assert property (p_force_zero) else $error("force bit stored");

  property p_res_zero;
    @(posedge ref_clk) disable iff (sys_rst) ctrl_b.reserved == 2'h0;
  endproperty
  a_res_zero: assert property (p_res_zero) else $error("reserved bits set");

  property p_ctc_clear;
    @(posedge ref_clk) disable iff (sys_rst)
      ev_a && !pwm_on && ctrl_b.clear_on_cmp && !wr_cnt |=> counter_value == '0;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("no clear on compare");

  property p_pwm_force;
    @(posedge ref_clk) disable iff (sys_rst)
      pwm_on && !ev_a |=> out_a == $past(out_a);
  endproperty
  a_pwm_force: assert property (p_pwm_force) else $error("force acted in pwm");

  property p_stop;
    @(posedge ref_clk) disable iff (sys_rst)
      ctrl_b.clk_sel == TMC_CS_STOP && !wr_cnt |=> $stable(counter_value);
  endproperty
  a_stop: assert property (p_stop) else $error("counter ran while stopped");

  property p_capture;
    @(posedge ref_clk) disable iff (sys_rst)
      cap_fire |=> capture_value == $past(counter_value) && capture_flag;
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_oe_a;
    @(posedge ref_clk) disable iff (sys_rst) cmp_a_pin.oe |-> dir_cmp_a;
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("pin a driven as input");
endmodule

// *** tmc_pin_model.sv ***
/*
  Pin-side partner of the timer block: drives the capture and count
  pins and resolves the two compare pins.
  Assumes the bench calls its tasks from one process, on ref_clk.
*/
`timescale 1ns/1ps
module tmc_pin_model
  import tmc_pkg::*;
(
  input wire logic ref_clk,
  input wire tmc_pin_t cmp_a_pin,
  input wire tmc_pin_t cmp_b_pin,
  output logic capture_pin,
  output logic count_pin,
  output logic wire_a,
  output logic wire_b
);
  // =====================================================================
  // compare pins: no pull, so a released pin shows the inverse of its last level
  logic last_a = 1'b0;
  logic last_b = 1'b0;
  always @(posedge ref_clk) begin
    if (cmp_a_pin.oe) last_a <= cmp_a_pin.out;
    if (cmp_b_pin.oe) last_b <= cmp_b_pin.out;
  end
  assign wire_a = cmp_a_pin.oe ? cmp_a_pin.out : ~last_a;
  assign wire_b = cmp_b_pin.oe ? cmp_b_pin.out : ~last_b;

  // =====================================================================
  // input pins idle: capture high, count low
  initial begin
    capture_pin = 1'b1;
    count_pin = 1'b0;
  end

  // three clocks high and four low between pulses, wider than the synchroniser needs
  task automatic count_pulses(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk) count_pin <= 1'b1;
      repeat (3) @(posedge ref_clk);
      count_pin <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
  endtask

  // level held for n clocks, so short pulses test the filter
  task automatic cap_hold(input logic v, input int n);
    @(posedge ref_clk) capture_pin <= v;
    repeat (n - 1) @(posedge ref_clk);
  endtask
endmodule

// *** tmc_timer_tb.sv ***
/*
  Self-checking bench for the timer control, compare and capture block.
  Assumes the pin model and the design files are compiled before it.
*/
`timescale 1ns/1ps
`include "tmc_defines.svh"
module tmc_timer_tb
  import tmc_pkg::*;
  ;
  typedef struct packed {
    logic [1:0] src;
    logic [15:0] exp;
  } tmc_note_t;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic dir_cmp_a = 1'b0;
  logic dir_cmp_b = 1'b0;
  tmc_pin_t cmp_a_pin;
  tmc_pin_t cmp_b_pin;
  logic capture_pin;
  logic count_pin;
  logic [2:0] flags;
  logic rd_q = 1'b0;
  logic probe_v = 1'b0;
  logic [15:0] meas = 16'h0000;
  logic [15:0] lfsr = 16'h0047;
  logic [1:0] modes[4] = '{2'h3, 2'h2, 2'h1, 2'h1};
  int divs[5] = '{1, 8, 64, 256, 1024};
  int mismatches = 0;
  int cmp_count = 0;
  tmc_note_t notes[$];

  // =====================================================================
  // clock, design and pin partner
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  tmc_timer dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .dir_cmp_a(dir_cmp_a), .dir_cmp_b(dir_cmp_b),
    .cmp_a_pin(cmp_a_pin), .cmp_b_pin(cmp_b_pin), .capture_pin(capture_pin),
    .count_pin(count_pin), .cmp_a_flag(flags[0]), .cmp_b_flag(flags[1]),
    .capture_flag(flags[2]));
  tmc_pin_model pins_u (.ref_clk(ref_clk), .cmp_a_pin(cmp_a_pin), .cmp_b_pin(cmp_b_pin),
    .capture_pin(capture_pin), .count_pin(count_pin), .wire_a(), .wire_b());

  // =====================================================================
  // shared tasks
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic conclude();
    $display("TB: counts compares=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    notes.push_back({2'h0, e});
    @(posedge ref_clk);
    reg_read <= 1'b0;
  endtask
  // high byte first: the low write commits both
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a + 8'h01, v[15:8]);
    wr(a, v[7:0]);
  endtask
  task automatic rd16(input logic [7:0] a, input logic [15:0] e);
    rd(a, {8'h00, e[7:0]});
    rd(a + 8'h01, {8'h00, e[15:8]});
  endtask
  task automatic probe(input logic [1:0] s, input logic [15:0] e);
    @(posedge ref_clk);
    probe_v <= 1'b1;
    notes.push_back({s, e});
    @(posedge ref_clk);
    probe_v <= 1'b0;
  endtask
  // clocks until compare pin a changes; bounded so a dead timer cannot hang
  task automatic gap(output int n);
    logic o;
    n = 0;
    @(negedge ref_clk);
    o = cmp_a_pin.out;
    while (cmp_a_pin.out === o && n < 5000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 5000) begin
      mismatches++;
      conclude();
    end
  endtask

  // =====================================================================
  // watcher: read data stand one cycle after the strobe, probes at once
  always @(posedge ref_clk) rd_q <= reg_read;
  always @(negedge ref_clk) begin
    tmc_note_t nt;
    logic [15:0] got;
    if (rd_q || probe_v) begin
      if (notes.size() == 0) begin
        nt = '0;
        mismatches++;
      end else begin
        nt = notes.pop_front();
      end
      case (nt.src)
        2'h0: got = {8'h00, reg_rdata};
        2'h1: got = {14'h0000, cmp_a_pin};
        2'h2: got = {14'h0000, cmp_b_pin};
        default: got = meas;
      endcase
      check(got, nt.exp);
    end
  end

  // =====================================================================
  // main sequence
  initial begin
    int n;
    logic [15:0] v;
    logic e;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(`TMC_OFS_CTRL_B, 16'h0000);
    wr(`TMC_OFS_CTRL_B, 8'hF8);
    rd(`TMC_OFS_CTRL_B, 16'h00C8);
    wr(`TMC_OFS_CTRL_B, 8'h00);
    wr(`TMC_OFS_CTRL_A, 8'h0D);
    rd(`TMC_OFS_CTRL_A, 16'h0001);
    wr(`TMC_OFS_CTRL_A, 8'h00);
    wr(8'h01, 8'hFF);
    rd(8'h01, 16'h0000);
    $display("TB: registers done");
    // turning edge select to rising while armed captures; start clean
    wr(`TMC_OFS_FLAGS, 8'h07);
    // forced actions; the first one still uses the old mode
    dir_cmp_a <= 1'b1;
    dir_cmp_b <= 1'b1;
    wr(`TMC_OFS_CTRL_A, 8'hC8);
    idle(2);
    probe(2'h1, 16'h0001);
    foreach (modes[i]) begin
      wr(`TMC_OFS_CTRL_A, {modes[i], 6'h30});
      wr(`TMC_OFS_CTRL_A, {modes[i], 6'h38});
      e = (i == 0) ? 1'b1 : (modes[i] == 2'h1) ? ~e : modes[i][0];
      idle(2);
      probe(2'h1, {14'h0000, e, 1'b1});
    end
    probe(2'h2, 16'h0001);
    dir_cmp_b <= 1'b0;
    probe(2'h2, 16'h0000);
    rd(`TMC_OFS_FLAGS, 16'h0000);
    for (int p = 1; p < 4; p++) begin
      wr(`TMC_OFS_CTRL_A, 8'h40 | 8'(p));
      wr(`TMC_OFS_CTRL_A, 8'h48 | 8'(p));
      rd(`TMC_OFS_CTRL_A, 16'h0040 | 16'(p));
      probe(2'h1, 16'h0001);
    end
    $display("TB: force done");
    // random compare b value, high bit set so it never matches below
    lfsr = lfsr_next(lfsr);
    v = lfsr | 16'h8000;
    wr16(`TMC_OFS_CMPB_LO, v);
    rd16(`TMC_OFS_CMPB_LO, v);
    // external count, clear on compare a at 3
    wr16(`TMC_OFS_CNT_LO, 16'h0000);
    wr16(`TMC_OFS_CMPA_LO, 16'h0003);
    wr(`TMC_OFS_CTRL_A, 8'h88);
    wr(`TMC_OFS_CTRL_A, 8'h40);
    wr(`TMC_OFS_FLAGS, 8'h07);
    wr(`TMC_OFS_CTRL_B, 8'h0F);
    lfsr = lfsr_next(lfsr);
    n = int'(lfsr[0]) + 1;
    pins_u.count_pulses(n);
    idle(6);
    rd16(`TMC_OFS_CNT_LO, 16'(n));
    pins_u.count_pulses(4 - n);
    idle(6);
    rd16(`TMC_OFS_CNT_LO, 16'h0000);
    rd(`TMC_OFS_FLAGS, 16'h0001);
    meas <= {13'h0000, flags};
    probe(2'h3, 16'h0001);
    probe(2'h1, 16'h0003);
    wr(`TMC_OFS_CTRL_B, 8'h06);
    pins_u.count_pulses(4);
    idle(6);
    rd16(`TMC_OFS_CNT_LO, 16'h0004);
    wr(`TMC_OFS_CTRL_B, 8'h0F);
    wr16(`TMC_OFS_CNT_LO, 16'h0003);
    wr(`TMC_OFS_FLAGS, 8'h07);
    pins_u.count_pulses(1);
    idle(6);
    rd16(`TMC_OFS_CNT_LO, 16'h0004);
    rd(`TMC_OFS_FLAGS, 16'h0000);
    $display("TB: count done");
    // compare value 1 with clear: pin toggles every two timer ticks
    wr16(`TMC_OFS_CMPA_LO, 16'h0001);
    for (int i = 1; i < 6; i++) begin
      wr(`TMC_OFS_CTRL_B, 8'h08);
      wr16(`TMC_OFS_CNT_LO, 16'h0000);
      wr(`TMC_OFS_CTRL_B, 8'h08 | 8'(i));
      gap(n);
      gap(n);
      meas <= 16'(n + 1);
      probe(2'h3, 16'(2 * divs[i - 1]));
    end
    $display("TB: prescaler done");
    // 8-bit pwm: up-down turns at top, down-count match sets the pin
    wr16(`TMC_OFS_CMPA_LO, 16'h00FE);
    wr(`TMC_OFS_CTRL_A, 8'h81);
    wr(`TMC_OFS_CTRL_B, 8'h07);
    wr16(`TMC_OFS_CNT_LO, 16'h00FF);
    pins_u.count_pulses(2);
    idle(6);
    rd16(`TMC_OFS_CNT_LO, 16'h00FD);
    probe(2'h1, 16'h0003);
    // wrap mode returns to zero after top
    wr(`TMC_OFS_CTRL_B, 8'h0F);
    wr16(`TMC_OFS_CNT_LO, 16'h00FF);
    pins_u.count_pulses(1);
    idle(6);
    rd16(`TMC_OFS_CNT_LO, 16'h0000);
    $display("TB: pwm done");
    // capture with a stopped counter
    wr(`TMC_OFS_CTRL_B, 8'h00);
    wr16(`TMC_OFS_CNT_LO, 16'h1234);
    wr(`TMC_OFS_FLAGS, 8'h07);
    pins_u.cap_hold(1'b0, 1);
    pins_u.cap_hold(1'b1, 8);
    rd(`TMC_OFS_FLAGS, 16'h0004);
    rd16(`TMC_OFS_CAP_LO, 16'h1234);
    wr(`TMC_OFS_CTRL_B, 8'h40);
    wr16(`TMC_OFS_CNT_LO, 16'h0456);
    wr(`TMC_OFS_FLAGS, 8'h07);
    pins_u.cap_hold(1'b0, 8);
    rd(`TMC_OFS_FLAGS, 16'h0000);
    pins_u.cap_hold(1'b1, 8);
    rd(`TMC_OFS_FLAGS, 16'h0004);
    rd16(`TMC_OFS_CAP_LO, 16'h0456);
    wr(`TMC_OFS_CTRL_B, 8'hC0);
    wr16(`TMC_OFS_CNT_LO, 16'h0789);
    pins_u.cap_hold(1'b0, 8);
    wr(`TMC_OFS_FLAGS, 8'h07);
    pins_u.cap_hold(1'b1, 3);
    pins_u.cap_hold(1'b0, 8);
    rd(`TMC_OFS_FLAGS, 16'h0000);
    pins_u.cap_hold(1'b1, 8);
    rd(`TMC_OFS_FLAGS, 16'h0004);
    rd16(`TMC_OFS_CAP_LO, 16'h0789);
    $display("TB: capture done");
    idle(2);
    conclude();
  end
endmodule
